/* tbd_pkg.sv */
// ==========================================================================
// time base and divider output constants
package tbd_pkg;

   // register indices and byte addresses (index times four)
   localparam logic [7:0]  TBD_IDX_TIME_BASE_CONTROL = 8'h36;
   localparam logic [7:0]  TBD_IDX_IRQ_STATUS        = 8'h37;
   localparam logic [7:0]  TBD_IDX_IRQ_CLEAR         = 8'h38;
   localparam logic [7:0]  TBD_IDX_IRQ_ENABLE        = 8'h39;
   localparam logic [11:0] TBD_ADDR_TIME_BASE_CONTROL = {2'h0, TBD_IDX_TIME_BASE_CONTROL, 2'h0};
   localparam logic [11:0] TBD_ADDR_IRQ_STATUS        = {2'h0, TBD_IDX_IRQ_STATUS, 2'h0};
   localparam logic [11:0] TBD_ADDR_IRQ_CLEAR         = {2'h0, TBD_IDX_IRQ_CLEAR, 2'h0};
   localparam logic [11:0] TBD_ADDR_IRQ_ENABLE        = {2'h0, TBD_IDX_IRQ_ENABLE, 2'h0};

   // time_base_control fields and reset value
   localparam int         TBD_BIT_BUZZER_OUT_ENABLE = 7;
   localparam int         TBD_POS_BUZZER_RATE       = 5;
   localparam int         TBD_BIT_DIVIDER_SOURCE    = 4;
   localparam int         TBD_BIT_TICK_ENABLE       = 3;
   localparam int         TBD_POS_TICK_RATE         = 0;
   localparam logic [7:0] TBD_RST_TIME_BASE_CONTROL = 8'h00;

   // interrupt status layout
   localparam int         TBD_IRQ_BIT_TICK = 0;
   localparam logic [0:0] TBD_RST_IRQ      = 1'h0;

   // divider chain
   localparam int          TBD_DIV_W   = 23;
   localparam logic [22:0] TBD_RST_DIV = 23'h000000;

   // divide exponents of the interrupt tap per rate code, high then low source
   localparam logic [4:0] TBD_TICK_EXP_FAST [8] = '{5'h17, 5'h15, 5'h10, 5'h0E, 5'h0D, 5'h0C, 5'h0B, 5'h09};
   localparam logic [4:0] TBD_TICK_EXP_SLOW [8] = '{5'h0F, 5'h0D, 5'h08, 5'h06, 5'h05, 5'h04, 5'h03, 5'h01};
   localparam logic [2:0] TBD_TICK_LOW_SPEED_MAX = 3'h1;

   // divide exponents of the buzzer tap per rate code
   localparam logic [4:0] TBD_BUZZ_EXP_FAST [4] = '{5'h0D, 5'h0C, 5'h0B, 5'h0A};
   localparam logic [4:0] TBD_BUZZ_EXP_SLOW [4] = '{5'h05, 5'h04, 5'h03, 5'h02};

endpackage : tbd_pkg

/* tbd_time_base.sv */
// Added by the designer: the APB register port.
`timescale 1ns/1ps
// ==========================================================================
// time base tick interrupt and buzzer divider output, APB slave
// Contract
// - periodic time-base interrupt request is provided to the CPU
// - one 8-bit control register at 0x36, reset zero, documented field layout
// - high-clock tick rates per code: 2^23,21,16,14,13,12,11,9
// - low-clock tick rates per code: 2^15,13,8,6,5,4,3,1
// - low-speed modes only allow tick codes 000 and 001
// - one write may set tick rate and tick enable together
// - interrupt on every falling edge of selected tap once enabled
// - register writes never reset the divider chain
// - buzzer pin carries an about 50% duty square wave, active low
// - buzzer output enable bit: 0 off, 1 on
// - high-clock buzzer rates per code: 2^13,12,11,10
// - low clock or low-speed modes give buzzer rates 2^5,4,3,2
module tbd_time_base (
   // apb
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   // clock sources and mode, same clock domain
   input  wire logic                 fc_tick,
   input  wire logic                 fs_tick,
   input  wire logic                 low_speed_mode,
   // outputs
   output logic                      tick_interrupt,
   output logic                      buzzer_out_n
);
   import tbd_pkg::*;

   // ==========================================================================
   // state
   typedef struct packed {
      logic [7:0]           ctrl;
      logic [0:0]           irq_status;
      logic [0:0]           irq_enable;
      logic [TBD_DIV_W-1:0] div;
      logic                 buzz_n;
      logic [31:0]          rdata;
      logic                 err;
   } tbd_state_t;

   tbd_state_t s;
   tbd_state_t next_s;

   // ==========================================================================
   // helpers
   // true when the counter is about to wrap below bit exp, i.e. tap exp-1 falls
   function automatic logic tbd_tap_fall(input logic [TBD_DIV_W-1:0] cnt, input logic [4:0] exp);
      logic [TBD_DIV_W-1:0] mask;
      mask = TBD_DIV_W'((24'h000001 << exp) - 24'h000001);
      return ((cnt & mask) == mask);
   endfunction : tbd_tap_fall

   function automatic logic tbd_tap_level(input logic [TBD_DIV_W-1:0] cnt, input logic [4:0] exp);
      logic [4:0] idx;
      idx = exp - 5'h01;
      return cnt[idx];
   endfunction : tbd_tap_level

   function automatic logic tbd_mapped(input logic [11:0] a);
      return (a == TBD_ADDR_TIME_BASE_CONTROL) || (a == TBD_ADDR_IRQ_STATUS) ||
             (a == TBD_ADDR_IRQ_CLEAR) || (a == TBD_ADDR_IRQ_ENABLE);
   endfunction : tbd_mapped

   // ==========================================================================
   // divider source and taps
   logic       use_slow;
   logic       src_tick;
   logic [2:0] tick_code;
   logic [1:0] buzz_code;
   logic [4:0] tick_exp;
   logic [4:0] buzz_exp;
   logic       tick_code_ok;
   logic       tick_evt;
   logic       setup;
   logic       access;
   logic       wr_ctrl;

   always_comb begin
      use_slow     = low_speed_mode | s.ctrl[TBD_BIT_DIVIDER_SOURCE];
      src_tick     = use_slow ? fs_tick : fc_tick;
      tick_code    = s.ctrl[TBD_POS_TICK_RATE +: 3];
      buzz_code    = s.ctrl[TBD_POS_BUZZER_RATE +: 2];
      tick_exp     = use_slow ? TBD_TICK_EXP_SLOW[tick_code] : TBD_TICK_EXP_FAST[tick_code];
      buzz_exp     = use_slow ? TBD_BUZZ_EXP_SLOW[buzz_code] : TBD_BUZZ_EXP_FAST[buzz_code];
      tick_code_ok = !low_speed_mode || (tick_code <= TBD_TICK_LOW_SPEED_MAX);
      tick_evt     = s.ctrl[TBD_BIT_TICK_ENABLE] && tick_code_ok && src_tick &&
                     tbd_tap_fall(s.div, tick_exp);
      setup        = psel && !penable;
      access       = psel && penable;
      wr_ctrl      = access && pwrite && (paddr == TBD_ADDR_TIME_BASE_CONTROL);
   end

   // ==========================================================================
   // next state
   always_comb begin
      next_s = s;
      // free-running chain, never cleared by software
      if (src_tick) begin
         next_s.div = s.div + TBD_DIV_W'(1);
      end
      // buzzer pin: inverted tap while enabled, else idle high
      if (s.ctrl[TBD_BIT_BUZZER_OUT_ENABLE]) begin
         next_s.buzz_n = !tbd_tap_level(s.div, buzz_exp);
      end else begin
         next_s.buzz_n = 1'b1;
      end
      // register writes on the access edge
      if (access && pwrite) begin
         case (paddr)
            TBD_ADDR_TIME_BASE_CONTROL: begin
               next_s.ctrl = pwdata[7:0];
            end
            TBD_ADDR_IRQ_CLEAR: begin
               next_s.irq_status = s.irq_status & ~pwdata[TBD_IRQ_BIT_TICK:TBD_IRQ_BIT_TICK];
            end
            TBD_ADDR_IRQ_ENABLE: begin
               next_s.irq_enable = pwdata[TBD_IRQ_BIT_TICK:TBD_IRQ_BIT_TICK];
            end
            default: begin
               next_s.ctrl = s.ctrl;
            end
         endcase
      end
      // event sets after any clear so set wins
      if (tick_evt) begin
         next_s.irq_status[TBD_IRQ_BIT_TICK] = 1'b1;
      end
      // read data and error captured in setup, presented in access
      if (setup) begin
         next_s.err   = !tbd_mapped(paddr);
         next_s.rdata = 32'h00000000;
         if (!pwrite) begin
            case (paddr)
               TBD_ADDR_TIME_BASE_CONTROL: begin
                  next_s.rdata = {24'h000000, s.ctrl};
               end
               TBD_ADDR_IRQ_STATUS: begin
                  next_s.rdata = {31'h00000000, s.irq_status};
               end
               TBD_ADDR_IRQ_ENABLE: begin
                  next_s.rdata = {31'h00000000, s.irq_enable};
               end
               default: begin
                  next_s.rdata = 32'h00000000;
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s.ctrl       <= TBD_RST_TIME_BASE_CONTROL;
         s.irq_status <= TBD_RST_IRQ;
         s.irq_enable <= TBD_RST_IRQ;
         s.div        <= TBD_RST_DIV;
         s.buzz_n     <= 1'b1;
         s.rdata      <= 32'h00000000;
         s.err        <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================================
   // outputs
   assign pready         = access;
   assign prdata         = s.rdata;
   assign pslverr        = access && s.err;
   assign tick_interrupt = |(s.irq_status & s.irq_enable);
   assign buzzer_out_n   = s.buzz_n;

   // ==========================================================================
   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   ctrl_write_a: assert property (wr_ctrl |=> s.ctrl == $past(pwdata[7:0]))
      else $error("control write not stored");

   ctrl_hold_a: assert property (!wr_ctrl |=> $stable(s.ctrl))
      else $error("control changed without write");

   div_count_a: assert property (src_tick |=> s.div == $past(s.div) + 23'h000001)
      else $error("divider did not advance on source tick");

   div_hold_a: assert property (!src_tick |=> $stable(s.div))
      else $error("divider moved without source tick");

   tick_cause_a: assert property ($rose(s.irq_status[0]) |-> $past(tick_evt))
      else $error("tick status rose without tap fall");

   tick_set_a: assert property (tick_evt |=> s.irq_status[0])
      else $error("tap fall did not set tick status");

   tick_tap_a: assert property (tick_evt && !use_slow && tick_code == 3'h7 |-> &s.div[8:0])
      else $error("fast tick code 7 not 2^9");

   low_speed_a: assert property (low_speed_mode && tick_code > 3'h1 |-> !tick_evt)
      else $error("tick in low-speed mode with invalid code");

   slow_tap_a: assert property (use_slow && tick_evt && tick_code == 3'h7 |-> s.div[0])
      else $error("slow tick code 7 not off first stage");

   buzz_off_a: assert property (!s.ctrl[7] |=> buzzer_out_n)
      else $error("buzzer pin active while disabled");

   buzz_wave_a: assert property (s.ctrl[7] |=> buzzer_out_n == !$past(s.div[buzz_exp - 5'h01]))
      else $error("buzzer pin not following tap");

   buzz_rate_a: assert property (s.ctrl[7] && !use_slow && buzz_code == 2'h0 |=>
                                 buzzer_out_n == !$past(s.div[12]))
      else $error("fast buzzer code 0 not 2^13");

   buzz_slow_a: assert property (s.ctrl[7] && use_slow && buzz_code == 2'h3 |=>
                                 buzzer_out_n == !$past(s.div[1]))
      else $error("slow buzzer code 3 not 2^2");

   buzz_enable_a: assert property ($rose(s.ctrl[7]) ##1 s.ctrl[7] |-> buzzer_out_n == !$past(s.div[buzz_exp - 5'h01]))
      else $error("buzzer not started after enable");

   irq_out_a: assert property (s.irq_status[0] && s.irq_enable[0] |-> tick_interrupt)
      else $error("interrupt output not raised");

   unmapped_a: assert property (setup && !tbd_mapped(paddr) ##1 access |-> pslverr)
      else $error("unmapped access without error");

   // ==========================================================================
   // per-code tap checks, written out from the rate tables
   fast_tick0_a: assert property (tick_evt && !use_slow && tick_code == 3'h0 |-> &s.div[22:0])
      else $error("fast tick code 0 not 2^23");

   fast_tick1_a: assert property (tick_evt && !use_slow && tick_code == 3'h1 |-> &s.div[20:0])
      else $error("fast tick code 1 not 2^21");

   fast_tick2_a: assert property (tick_evt && !use_slow && tick_code == 3'h2 |-> &s.div[15:0])
      else $error("fast tick code 2 not 2^16");

   fast_tick3_a: assert property (tick_evt && !use_slow && tick_code == 3'h3 |-> &s.div[13:0])
      else $error("fast tick code 3 not 2^14");

   fast_tick4_a: assert property (tick_evt && !use_slow && tick_code == 3'h4 |-> &s.div[12:0])
      else $error("fast tick code 4 not 2^13");

   fast_tick5_a: assert property (tick_evt && !use_slow && tick_code == 3'h5 |-> &s.div[11:0])
      else $error("fast tick code 5 not 2^12");

   fast_tick6_a: assert property (tick_evt && !use_slow && tick_code == 3'h6 |-> &s.div[10:0])
      else $error("fast tick code 6 not 2^11");

   slow_tick0_a: assert property (tick_evt && use_slow && tick_code == 3'h0 |-> &s.div[14:0])
      else $error("slow tick code 0 not 2^15");

   slow_tick1_a: assert property (tick_evt && use_slow && tick_code == 3'h1 |-> &s.div[12:0])
      else $error("slow tick code 1 not 2^13");

   slow_tick2_a: assert property (tick_evt && use_slow && tick_code == 3'h2 |-> &s.div[7:0])
      else $error("slow tick code 2 not 2^8");

   slow_tick3_a: assert property (tick_evt && use_slow && tick_code == 3'h3 |-> &s.div[5:0])
      else $error("slow tick code 3 not 2^6");

   slow_tick4_a: assert property (tick_evt && use_slow && tick_code == 3'h4 |-> &s.div[4:0])
      else $error("slow tick code 4 not 2^5");

   slow_tick5_a: assert property (tick_evt && use_slow && tick_code == 3'h5 |-> &s.div[3:0])
      else $error("slow tick code 5 not 2^4");

   slow_tick6_a: assert property (tick_evt && use_slow && tick_code == 3'h6 |-> &s.div[2:0])
      else $error("slow tick code 6 not 2^3");

   fast_buzz1_a: assert property (s.ctrl[7] && !use_slow && buzz_code == 2'h1 |=>
                                  buzzer_out_n == !$past(s.div[11]))
      else $error("fast buzzer code 1 not 2^12");

   fast_buzz2_a: assert property (s.ctrl[7] && !use_slow && buzz_code == 2'h2 |=>
                                  buzzer_out_n == !$past(s.div[10]))
      else $error("fast buzzer code 2 not 2^11");

   fast_buzz3_a: assert property (s.ctrl[7] && !use_slow && buzz_code == 2'h3 |=>
                                  buzzer_out_n == !$past(s.div[9]))
      else $error("fast buzzer code 3 not 2^10");

   slow_buzz0_a: assert property (s.ctrl[7] && use_slow && buzz_code == 2'h0 |=>
                                  buzzer_out_n == !$past(s.div[4]))
      else $error("slow buzzer code 0 not 2^5");

   slow_buzz1_a: assert property (s.ctrl[7] && use_slow && buzz_code == 2'h1 |=>
                                  buzzer_out_n == !$past(s.div[3]))
      else $error("slow buzzer code 1 not 2^4");

   slow_buzz2_a: assert property (s.ctrl[7] && use_slow && buzz_code == 2'h2 |=>
                                  buzzer_out_n == !$past(s.div[2]))
      else $error("slow buzzer code 2 not 2^3");

   // ==========================================================================
   // bus, status and source checks
   pready_a: assert property (pready == (psel && penable))
      else $error("ready not equal to access phase");

   err_only_a: assert property (pslverr |-> pready)
      else $error("error outside access phase");

   mapped_ok_a: assert property (setup && tbd_mapped(paddr) ##1 access |-> !pslverr)
      else $error("mapped access flagged as error");

   ctrl_read_a: assert property (setup && !pwrite && paddr == TBD_ADDR_TIME_BASE_CONTROL |=>
                                 prdata == {24'h000000, $past(s.ctrl)})
      else $error("control read data wrong");

   irq_clear_a: assert property (access && pwrite && paddr == TBD_ADDR_IRQ_CLEAR && pwdata[0] && !tick_evt
                                 |=> !s.irq_status[0])
      else $error("status not cleared by write");

   status_hold_a: assert property (s.irq_status[0] && !(access && pwrite && paddr == TBD_ADDR_IRQ_CLEAR)
                                   |=> s.irq_status[0])
      else $error("status dropped without clear");

   set_wins_a: assert property (tick_evt && access && pwrite && paddr == TBD_ADDR_IRQ_CLEAR
                                |=> s.irq_status[0])
      else $error("clear beat same-cycle tick event");

   status_ro_a: assert property (access && pwrite && paddr == TBD_ADDR_IRQ_STATUS && !tick_evt
                                 |=> $stable(s.irq_status))
      else $error("status changed by write");

   enable_write_a: assert property (access && pwrite && paddr == TBD_ADDR_IRQ_ENABLE
                                    |=> s.irq_enable[0] == $past(pwdata[0]))
      else $error("interrupt enable write not stored");

   irq_masked_a: assert property (!s.irq_enable[0] |-> !tick_interrupt)
      else $error("interrupt raised while masked");

   unmapped_write_a: assert property (access && pwrite && !tbd_mapped(paddr)
                                      |=> $stable(s.ctrl) && $stable(s.irq_enable))
      else $error("unmapped write changed a register");

   tick_off_a: assert property (!s.ctrl[TBD_BIT_TICK_ENABLE] |-> !tick_evt)
      else $error("tick event while disabled");

   src_fast_a: assert property (!low_speed_mode && !s.ctrl[TBD_BIT_DIVIDER_SOURCE] |-> src_tick == fc_tick)
      else $error("full-speed source not high clock");

   src_slow_a: assert property (low_speed_mode |-> src_tick == fs_tick)
      else $error("low-speed source not low clock");

   tick_seen_c:   cover property (tick_evt ##1 tick_interrupt);
   low_speed_c:   cover property (low_speed_mode && tick_evt);
   buzz_toggle_c: cover property (s.ctrl[7] ##1 $fell(buzzer_out_n));
   enable_rate_c: cover property (wr_ctrl && pwdata[3] && pwdata[2:0] != 3'h0);
   clear_race_c:  cover property (tick_evt && access && pwrite && paddr == TBD_ADDR_IRQ_CLEAR);

endmodule : tbd_time_base

/* tbd_buzzer_probe.sv */
`timescale 1ns/1ps
// ==========================================================================
// far side: buzzer pin watcher, measures cycles between pin changes
module tbd_buzzer_probe (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // observed pin
   input  wire logic        buzzer_out_n,
   // measurement
   output logic [15:0]      half_period
);
   logic [15:0] run;
   logic        last;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_period <= 16'h0000;
         run         <= 16'h0000;
         last        <= 1'b1;
      end else begin
         last <= buzzer_out_n;
         if (buzzer_out_n !== last) begin
            half_period <= run + 16'h0001;
            run         <= 16'h0000;
         end else begin
            run <= run + 16'h0001;
         end
      end
   end
endmodule : tbd_buzzer_probe

/* test_time_base_and_divider_output.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; $display("Error %s expected %0h seen %0h", n, e, s); end end
module test_time_base_and_divider_output;
   import tbd_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
   logic        fc_tick, fs_tick, low_speed_mode, tick_interrupt, buzzer_out_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [15:0] half_period;
   logic [7:0]  cur, v;
   int          miscompares, comparisons, cycles, seed;
   int          texp [8] = '{15, 13, 8, 6, 5, 4, 3, 1};
   longint      t0;

   tbd_time_base dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .fc_tick(fc_tick),
      .fs_tick(fs_tick), .low_speed_mode(low_speed_mode), .tick_interrupt(tick_interrupt),
      .buzzer_out_n(buzzer_out_n));
   tbd_buzzer_probe probe (.pclk(pclk), .presetn(presetn), .buzzer_out_n(buzzer_out_n),
      .half_period(half_period));

   // ==========================================================================
   // clock, timeout, closing
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         conclude();
      end
   end

   task automatic conclude();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude

   // ==========================================================================
   // apb master and helpers
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // rate changes only with the tick stopped, old rate kept while stopping
   task automatic tick_check(input logic [7:0] cv, input longint per);
      apb(1'b1, TBD_ADDR_TIME_BASE_CONTROL, {24'h0, cur & 8'hF7});
      apb(1'b1, TBD_ADDR_IRQ_CLEAR, 32'h1);
      apb(1'b1, TBD_ADDR_TIME_BASE_CONTROL, {24'h0, cv});
      cur = cv;
      while (tick_interrupt !== 1'b1) @(posedge pclk);
      t0 = $time;
      apb(1'b1, TBD_ADDR_IRQ_CLEAR, 32'h1);
      while (tick_interrupt !== 1'b0) @(posedge pclk);
      while (tick_interrupt !== 1'b1) @(posedge pclk);
      `CHK("tick_period", per, ($time - t0) / 8)
   endtask : tick_check

   // ==========================================================================
   // main sequence
   initial begin
      seed = 96769;
      {psel, penable, pwrite, paddr, pwdata, low_speed_mode, cur} = '0;
      {fc_tick, fs_tick} = 2'b11;
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, TBD_ADDR_TIME_BASE_CONTROL, 32'h0);
      `CHK("ctrl_reset", 32'h0, r)
      `CHK("buzz_reset", 1'b1, buzzer_out_n)
      v = 8'($random(seed)) & 8'h77;
      apb(1'b1, TBD_ADDR_TIME_BASE_CONTROL, {24'h0, v});
      apb(1'b0, TBD_ADDR_TIME_BASE_CONTROL, 32'h0);
      `CHK("ctrl_rw", {24'h0, v}, r)
      apb(1'b1, 12'h004, 32'h5A);
      `CHK("unmapped_err", 1'b1, serr)
      $display("registers done");
      for (int c = 0; c < 5; c++) begin
         v = (c < 4) ? {1'b0, 2'(c), 5'h10} : 8'h60;
         apb(1'b1, TBD_ADDR_TIME_BASE_CONTROL, {24'h0, v});
         apb(1'b1, TBD_ADDR_TIME_BASE_CONTROL, {24'h0, v | 8'h80});
         repeat (((c < 4) ? (16 >> c) : 512) * 3 + 8) @(posedge pclk);
         `CHK("buzz_half", 16'((c < 4) ? (16 >> c) : 512), half_period)
         apb(1'b1, TBD_ADDR_TIME_BASE_CONTROL, {24'h0, v});
      end
      repeat (4) @(posedge pclk);
      v = 8'h00;
      repeat (64) begin
         @(posedge pclk);
         v = v | {7'h0, ~buzzer_out_n};
      end
      `CHK("buzz_off", 8'h00, v)
      $display("buzzer done");
      apb(1'b1, TBD_ADDR_IRQ_ENABLE, 32'h1);
      for (int c = 2; c < 7; c++) tick_check({5'h03, 3'(c)}, longint'(1) << texp[c]);
      tick_check(8'h0F, 512);
      apb(1'b1, TBD_ADDR_IRQ_ENABLE, 32'h0);
      repeat (600) @(posedge pclk);
      `CHK("irq_masked", 1'b0, tick_interrupt)
      apb(1'b0, TBD_ADDR_IRQ_STATUS, 32'h0);
      `CHK("status_sticky", 32'h1, r)
      apb(1'b1, TBD_ADDR_IRQ_ENABLE, 32'h1);
      @(posedge pclk);
      `CHK("irq_level", 1'b1, tick_interrupt)
      $display("tick done");
      low_speed_mode <= 1'b1;
      apb(1'b1, TBD_ADDR_TIME_BASE_CONTROL, {24'h0, cur & 8'hF7});
      apb(1'b1, TBD_ADDR_TIME_BASE_CONTROL, 32'h0A);
      cur = 8'h0A;
      apb(1'b1, TBD_ADDR_IRQ_CLEAR, 32'h1);
      repeat (600) @(posedge pclk);
      `CHK("low_speed_none", 1'b0, tick_interrupt)
      tick_check(8'h09, 8192);
      $display("low speed done");
      conclude();
   end
endmodule : test_time_base_and_divider_output
